// File: verilog/bmf_exec.v
`timescale 1ns/1ns
`include "bmf_regs.vh"

module bmf_exec (
  ref_clk,
  reset,
  op_valid,
  op_first,
  op_second,
  word_count_reg,
  source_pointer,
  destination_pointer,
  mem_rdata,
  mem_wait,
  flag_strobe,
  flag_rule,
  carry11,
  carry27,
  result_zero,
  adj_carry,
  divisor_neg,
  divisor_zero,
  quotient_neg,
  busy_r,
  done_r,
  word_mode_r,
  count_out_r,
  source_out_r,
  dest_out_r,
  exec_states_r,
  mem_addr_r,
  mem_rd_r,
  mem_wr_r,
  mem_wdata_r,
  ccr_r
);
  input wire ref_clk;
  input wire reset;
  input wire op_valid;
  input wire [7:0] op_first;
  input wire [7:0] op_second;
  input wire [15:0] word_count_reg;
  input wire [15:0] source_pointer;
  input wire [15:0] destination_pointer;
  input wire [7:0] mem_rdata;
  input wire mem_wait;
  input wire flag_strobe;
  input wire [2:0] flag_rule;
  input wire carry11;
  input wire carry27;
  input wire result_zero;
  input wire adj_carry;
  input wire divisor_neg;
  input wire divisor_zero;
  input wire quotient_neg;
  output reg busy_r;
  output reg done_r;
  output reg word_mode_r;
  output reg [15:0] count_out_r;
  output reg [15:0] source_out_r;
  output reg [15:0] dest_out_r;
  output reg [19:0] exec_states_r;
  output reg [15:0] mem_addr_r;
  output reg mem_rd_r;
  output reg mem_wr_r;
  output reg [7:0] mem_wdata_r;
  output reg [7:0] ccr_r;

  // ----------------------------------------------------------------------
  // Copy sequencer states
  // ----------------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_SETUP = 6'b00_0010;
  localparam [5:0] ST_RD_REQ = 6'b00_0100;
  localparam [5:0] ST_RD_DATA = 6'b00_1000;
  localparam [5:0] ST_WR_REQ = 6'b01_0000;
  localparam [5:0] ST_WR_DONE = 6'b10_0000;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [3:0] setup_cnt_r;
  reg [7:0] data_r;

  wire dec_copy;
  wire dec_word;
  wire [7:0] ccr_nxt;
  wire start;
  wire [7:0] byte_count_reg;
  wire count_zero;
  wire last_byte;
  wire [15:0] count_dec;

  // ----------------------------------------------------------------------
  // Opcode split and flag datapath
  // ----------------------------------------------------------------------
  bmf_op_split u_split (
    .first_byte(op_first),
    .second_byte(op_second),
    .is_copy(dec_copy),
    .is_word(dec_word)
  );

  bmf_flag_unit u_flags (
    .ccr_in(ccr_r),
    .rule(flag_rule),
    .carry11(carry11),
    .carry27(carry27),
    .result_zero(result_zero),
    .adj_carry(adj_carry),
    .divisor_neg(divisor_neg),
    .divisor_zero(divisor_zero),
    .quotient_neg(quotient_neg),
    .ccr_out(ccr_nxt)
  );

  // The byte count is the low half of the word count register.
  assign byte_count_reg = word_count_reg[7:0];
  assign start = op_valid & dec_copy & state_r[0];

  // Zero tests look only at the part of the count the form uses.
  assign count_zero = word_mode_r ? (count_out_r == `BMF_ZERO16) :
                      (count_out_r[7:0] == `BMF_ZERO8);
  assign last_byte = word_mode_r ? (count_out_r == `BMF_ONE16) :
                     (count_out_r[7:0] == `BMF_ONE8);

  // Byte form must not borrow into the upper byte of the register.
  assign count_dec = word_mode_r ? (count_out_r - `BMF_ONE16) :
                     {count_out_r[15:8], count_out_r[7:0] - `BMF_ONE8};

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Four states per byte when the memory never waits; any wait from an
  // external or sync-clock transfer stretches ST_RD_DATA and ST_WR_DONE.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setup_cnt_r == `BMF_SETUP_LAST) begin
          state_nxt = count_zero ? ST_IDLE : ST_RD_REQ;
        end
      end
      ST_RD_REQ: begin
        state_nxt = ST_RD_DATA;
      end
      ST_RD_DATA: begin
        if (!mem_wait) begin
          state_nxt = ST_WR_REQ;
        end
      end
      ST_WR_REQ: begin
        state_nxt = ST_WR_DONE;
      end
      ST_WR_DONE: begin
        if (!mem_wait) begin
          state_nxt = last_byte ? ST_IDLE : ST_RD_REQ;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer, pointers and count
  // ----------------------------------------------------------------------
  // Pointers and count are working copies loaded at start; the register
  // file picks them up from the outputs once done pulses.
  always @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      setup_cnt_r <= 4'h0;
      word_mode_r <= 1'b0;
      count_out_r <= `BMF_ZERO16;
      source_out_r <= `BMF_ZERO16;
      dest_out_r <= `BMF_ZERO16;
      data_r <= `BMF_ZERO8;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE: begin
          setup_cnt_r <= 4'h0;
          if (start) begin
            word_mode_r <= dec_word;
            count_out_r <= dec_word ? word_count_reg :
                           {word_count_reg[15:8], byte_count_reg};
            source_out_r <= source_pointer;
            dest_out_r <= destination_pointer;
          end
        end
        ST_SETUP: begin
          setup_cnt_r <= setup_cnt_r + 4'h1;
        end
        ST_RD_DATA: begin
          if (!mem_wait) begin
            data_r <= mem_rdata;
          end
        end
        ST_WR_DONE: begin
          if (!mem_wait) begin
            source_out_r <= source_out_r + `BMF_ONE16;
            dest_out_r <= dest_out_r + `BMF_ONE16;
            count_out_r <= count_dec;
          end
        end
        default: begin
          setup_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Memory strobes
  // ----------------------------------------------------------------------
  // Strobes are registered, so they stand one state after the request
  // state and are held through every wait state.
  always @(posedge ref_clk) begin
    if (reset) begin
      mem_addr_r <= `BMF_ZERO16;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_wdata_r <= `BMF_ZERO8;
    end else begin
      case (state_nxt)
        ST_RD_DATA: begin
          mem_rd_r <= 1'b1;
          mem_wr_r <= 1'b0;
          mem_addr_r <= source_out_r;
        end
        ST_WR_DONE: begin
          mem_rd_r <= 1'b0;
          mem_wr_r <= 1'b1;
          mem_addr_r <= dest_out_r;
          mem_wdata_r <= (state_r == ST_RD_DATA) ? mem_rdata : data_r;
        end
        default: begin
          mem_rd_r <= 1'b0;
          mem_wr_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Busy, done and the execution-state count
  // ----------------------------------------------------------------------
  // The count covers every state from the first setup state to the last
  // write, giving 8 + 4n with on-chip memory and more with waits.
  always @(posedge ref_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      exec_states_r <= 20'h0_0000;
    end else begin
      busy_r <= !state_nxt[0];
      done_r <= !state_r[0] & state_nxt[0];
      if (start) begin
        exec_states_r <= `BMF_ST_CNT_ONE;
      end else if (!state_r[0] && !state_nxt[0]) begin
        exec_states_r <= exec_states_r + `BMF_ST_CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Condition-code register
  // ----------------------------------------------------------------------
  // Only the flag strobe writes the flags; the copy sequencer has no path
  // to them, so a copy cannot disturb them in either form.
  always @(posedge ref_clk) begin
    if (reset) begin
      ccr_r <= `BMF_CCR_RST;
    end else if (flag_strobe) begin
      ccr_r <= ccr_nxt;
    end
  end
endmodule

// File: verilog/bmf_regs.vh
`ifndef BMF_REGS_VH
`define BMF_REGS_VH

// ----------------------------------------------------------------------
// Condition-code register layout and reset value
// ----------------------------------------------------------------------
`define BMF_CCR_W 8
`define BMF_CCR_RST 8'h80
`define BMF_CCR_H 5
`define BMF_CCR_N 3
`define BMF_CCR_Z 2
`define BMF_CCR_C 0

// ----------------------------------------------------------------------
// Execution-state figures for the block copy
// ----------------------------------------------------------------------
`define BMF_SETUP_STATES 4'h8
`define BMF_SETUP_LAST 4'h7
`define BMF_ST_CNT_W 20
`define BMF_ST_CNT_ONE 20'h0_0001

// ----------------------------------------------------------------------
// Opcode bytes and the bit that splits a second byte
// ----------------------------------------------------------------------
`define BMF_OP_COPY 8'h7B
`define BMF_SPLIT_BIT 7

// ----------------------------------------------------------------------
// Flag rule selectors
// ----------------------------------------------------------------------
`define BMF_RULE_W 3
`define BMF_RULE_NONE 3'h0
`define BMF_RULE_HC11 3'h1
`define BMF_RULE_HC27 3'h2
`define BMF_RULE_ZEXT 3'h3
`define BMF_RULE_DADJ 3'h4
`define BMF_RULE_DIVS 3'h5
`define BMF_RULE_DIVZ 3'h6
`define BMF_RULE_DIVQ 3'h7

// ----------------------------------------------------------------------
// Data widths and small constants
// ----------------------------------------------------------------------
`define BMF_ADDR_W 16
`define BMF_CNT_W 16
`define BMF_ONE16 16'h0001
`define BMF_ZERO16 16'h0000
`define BMF_ZERO8 8'h00
`define BMF_ONE8 8'h01

`endif

// File: verilog/bmf_op_split.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Second-byte split of the copy opcode
// ----------------------------------------------------------------------
`include "bmf_regs.vh"

module bmf_op_split (
  first_byte,
  second_byte,
  is_copy,
  is_word
);
  input wire [7:0] first_byte;
  input wire [7:0] second_byte;
  output wire is_copy;
  output wire is_word;

  // The top bit of the second byte's upper nibble picks the form.
  assign is_copy = (first_byte == `BMF_OP_COPY);
  assign is_word = is_copy & second_byte[`BMF_SPLIT_BIT];
endmodule

// File: verilog/bmf_flag_unit.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Condition flag update for the footnoted rules
// ----------------------------------------------------------------------
`include "bmf_regs.vh"

module bmf_flag_unit (
  ccr_in,
  rule,
  carry11,
  carry27,
  result_zero,
  adj_carry,
  divisor_neg,
  divisor_zero,
  quotient_neg,
  ccr_out
);
  input wire [7:0] ccr_in;
  input wire [2:0] rule;
  input wire carry11;
  input wire carry27;
  input wire result_zero;
  input wire adj_carry;
  input wire divisor_neg;
  input wire divisor_zero;
  input wire quotient_neg;
  output reg [7:0] ccr_out;

  // Each rule touches only its own flag; all other bits pass through.
  always @* begin
    ccr_out = ccr_in;
    case (rule)
      `BMF_RULE_HC11: ccr_out[`BMF_CCR_H] = carry11;
      `BMF_RULE_HC27: ccr_out[`BMF_CCR_H] = carry27;
      `BMF_RULE_ZEXT: ccr_out[`BMF_CCR_Z] = ccr_in[`BMF_CCR_Z] & result_zero;
      `BMF_RULE_DADJ: ccr_out[`BMF_CCR_C] = ccr_in[`BMF_CCR_C] | adj_carry;
      `BMF_RULE_DIVS: ccr_out[`BMF_CCR_N] = divisor_neg;
      `BMF_RULE_DIVZ: ccr_out[`BMF_CCR_Z] = divisor_zero;
      `BMF_RULE_DIVQ: ccr_out[`BMF_CCR_N] = quotient_neg;
      default: ccr_out = ccr_in;
    endcase
  end
endmodule

// File: tb/bmf_exec_props.sv
`timescale 1ns/1ns
// --------------------
// Copy and flag checks
// --------------------
module bmf_exec_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic flag_strobe,
  input wire logic [2:0] flag_rule,
  input wire logic carry11,
  input wire logic carry27,
  input wire logic result_zero,
  input wire logic adj_carry,
  input wire logic divisor_neg,
  input wire logic divisor_zero,
  input wire logic quotient_neg,
  input wire logic mem_wait,
  input wire logic [7:0] mem_rdata,
  input wire logic busy_r,
  input wire logic mem_rd_r,
  input wire logic mem_wr_r,
  input wire logic [15:0] mem_addr_r,
  input wire logic [7:0] mem_wdata_r,
  input wire logic [7:0] ccr_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Flags may only move one cycle after a strobe, never because of a copy.
  a_flags_hold: assert property (!$past(flag_strobe) |-> $stable(ccr_r))
    else $error("flags changed without a strobe");
  a_half_c11: assert property (flag_strobe && flag_rule == 3'h1 |=> ccr_r[5] == $past(carry11))
    else $error("half carry from bit 11 wrong");
  a_half_c27: assert property (flag_strobe && flag_rule == 3'h2 |=> ccr_r[5] == $past(carry27))
    else $error("half carry from bit 27 wrong");
  a_zero_kept: assert property (flag_strobe && flag_rule == 3'h3 |=>
    ccr_r[2] == ($past(ccr_r[2]) & $past(result_zero)))
    else $error("extended zero wrong");
  a_adj_carry: assert property (flag_strobe && flag_rule == 3'h4 |=>
    ccr_r[0] == ($past(ccr_r[0]) | $past(adj_carry)))
    else $error("adjust carry wrong");
  a_div_neg: assert property (flag_strobe && flag_rule == 3'h5 |=> ccr_r[3] == $past(divisor_neg))
    else $error("negative divisor flag wrong");
  a_div_zero: assert property (flag_strobe && flag_rule == 3'h6 |=> ccr_r[2] == $past(divisor_zero))
    else $error("zero divisor flag wrong");
  a_quot_neg: assert property (flag_strobe && flag_rule == 3'h7 |=> ccr_r[3] == $past(quotient_neg))
    else $error("negative quotient flag wrong");
  a_idle_quiet: assert property (!busy_r |-> !mem_rd_r && !mem_wr_r)
    else $error("memory strobe while idle");
  // The read is taken two edges before the write strobe is seen high; the request state
  // in between leaves both strobes low.
  a_wr_after_rd: assert property ($rose(mem_wr_r) |-> $past(mem_rd_r, 2) && mem_wdata_r == $past(mem_rdata, 2))
    else $error("written byte is not the byte read");
  a_wait_holds: assert property (mem_wr_r && mem_wait |=> mem_wr_r && $stable(mem_addr_r))
    else $error("write strobe dropped during a stall");
endmodule

bind bmf_exec bmf_exec_props u_props (.ref_clk, .reset, .flag_strobe, .flag_rule, .carry11,
  .carry27, .result_zero, .adj_carry, .divisor_neg, .divisor_zero, .quotient_neg, .mem_wait,
  .mem_rdata, .busy_r, .mem_rd_r, .mem_wr_r, .mem_addr_r, .mem_wdata_r, .ccr_r);

// File: tb/bmf_mem_model.sv
`timescale 1ns/1ns
// --------------------
// Byte memory partner
// --------------------
module bmf_mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_wait
);
  logic [7:0] mem [0:1023];
  logic [7:0] last_r = 8'h00;
  logic stalled_r = 1'b0;
  // A slow part stalls the first cycle of every strobe, reads and writes alike, so both hold
  // paths are used and the state count grows by two per byte.
  assign mem_wait = slow && !stalled_r && (mem_rd || mem_wr);
  // Outside a taken read the bus shows the inverse of the last byte, never stale data.
  assign mem_rdata = (mem_rd && !mem_wait) ? mem[mem_addr[9:0]] : ~last_r;
  // Reads and writes complete only on a cycle without a stall.
  always @(posedge ref_clk) begin
    if (mem_wait) stalled_r <= 1'b1;
    else if (mem_rd || mem_wr) stalled_r <= 1'b0;
    if (mem_rd && !mem_wait) last_r <= mem_rdata;
    if (mem_wr && !mem_wait) mem[mem_addr[9:0]] <= mem_wdata;
  end
endmodule

// File: tb/block_move_and_flag_exec_bench.sv
`timescale 1ns/1ns
// --------------------
// Copy and flag bench
// --------------------
module block_move_and_flag_exec_bench;
  logic ref_clk = 0, reset = 1, op_valid = 0, flag_strobe = 0, slow = 0;
  logic [7:0] op_first = 0, op_second = 0, ccr_exp = 8'h80;
  logic [15:0] word_count_reg = 0, source_pointer = 0, destination_pointer = 0;
  logic [2:0] flag_rule = 0;
  logic [6:0] ev = 0;
  wire busy_r, done_r, word_mode_r, mem_rd_r, mem_wr_r, mem_wait;
  wire [15:0] count_out_r, source_out_r, dest_out_r, mem_addr_r;
  wire [19:0] exec_states_r;
  wire [7:0] mem_wdata_r, ccr_r, mem_rdata;
  integer miscompares = 0, tests_run = 0;
  int i, p, r;

  bmf_exec dut (.ref_clk, .reset, .op_valid, .op_first, .op_second, .word_count_reg,
    .source_pointer, .destination_pointer, .mem_rdata, .mem_wait, .flag_strobe, .flag_rule,
    .carry11(ev[0]), .carry27(ev[1]), .result_zero(ev[2]), .adj_carry(ev[3]),
    .divisor_neg(ev[4]), .divisor_zero(ev[5]), .quotient_neg(ev[6]), .busy_r, .done_r,
    .word_mode_r, .count_out_r, .source_out_r, .dest_out_r, .exec_states_r, .mem_addr_r,
    .mem_rd_r, .mem_wr_r, .mem_wdata_r, .ccr_r);
  bmf_mem_model mem_m (.ref_clk, .slow, .mem_addr(mem_addr_r), .mem_rd(mem_rd_r),
    .mem_wr(mem_wr_r), .mem_wdata(mem_wdata_r), .mem_rdata, .mem_wait);

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 ref_clk = ~ref_clk;

  task chk(input string nm, input [19:0] e, input [19:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Only the selected event input carries vv; all others carry the opposite, so a rule that
  // looks at the wrong input shows up.
  task flag(input [2:0] rl, input vv);
    @(negedge ref_clk);
    flag_strobe = 1;
    flag_rule = rl;
    ev = {7{~vv}} ^ (7'd1 << (rl - 3'd1));
    case (rl)
      3'h1, 3'h2: ccr_exp[5] = vv;
      3'h3: ccr_exp[2] = ccr_exp[2] & vv;
      3'h4: ccr_exp[0] = ccr_exp[0] | vv;
      3'h5, 3'h7: ccr_exp[3] = vv;
      3'h6: ccr_exp[2] = vv;
      default: ;
    endcase
    @(posedge ref_clk);
    #1 chk("ccr_r", ccr_exp, ccr_r);
  endtask

  task copy(input w, input [15:0] cnt, input [15:0] src, input [15:0] dst, input sl);
    int k, wt, n;
    logic [7:0] cc, old;
    n = w ? cnt : cnt[7:0];
    cc = ccr_r;
    old = mem_m.mem[dst[9:0]];
    @(negedge ref_clk);
    op_valid = 1;
    op_first = 8'h7B;
    op_second = w ? 8'hD4 : 8'h5C;
    word_count_reg = cnt;
    source_pointer = src;
    destination_pointer = dst;
    slow = sl;
    @(negedge ref_clk);
    op_valid = 0;
    k = 1;
    wt = 0;
    while (done_r !== 1'b1 && k < 3000) begin
      if (mem_wait && (mem_rd_r || mem_wr_r)) wt++;
      @(negedge ref_clk);
      k++;
    end
    chk("done cycle", 9 + 4 * n + wt, k);
    chk("exec_states_r", 8 + 4 * n + wt, exec_states_r);
    chk("count_out_r", w ? 16'h0000 : {cnt[15:8], 8'h00}, count_out_r);
    chk("source_out_r", src + n, source_out_r);
    chk("dest_out_r", dst + n, dest_out_r);
    chk("word_mode_r", w, word_mode_r);
    chk("ccr_r", cc, ccr_r);
    for (k = 0; k < n; k++) chk("copied byte", mem_m.mem[src[9:0] + k], mem_m.mem[dst[9:0] + k]);
    if (n == 0) chk("skipped byte", old, mem_m.mem[dst[9:0]]);
    @(negedge ref_clk);
    chk("done_r pulse", 0, done_r);
    $display("test copy of %0d bytes done", n);
  endtask

  // Main sequence: reset, flag rules, a foreign opcode, then the copy forms.
  initial begin
    for (i = 0; i < 1024; i++) mem_m.mem[i] = i[9:2];
    repeat (2) @(negedge ref_clk);
    reset = 0;
    chk("ccr_r reset", 8'h80, ccr_r);
    chk("busy_r reset", 0, busy_r);
    $display("test reset done");
    for (p = 0; p < 3; p++)
      for (r = 7; r >= 0; r--) flag(r[2:0], p[1] | (p[0] ^ r[0]));
    // Carry is set here, so an adjust without carry must keep it set.
    flag(3'h4, 1'b0);
    @(negedge ref_clk);
    flag_strobe = 0;
    $display("test flags done");
    op_valid = 1;
    op_first = 8'h7A;
    repeat (12) @(negedge ref_clk);
    op_valid = 0;
    chk("busy_r other opcode", 0, busy_r);
    $display("test other opcode done");
    copy(0, 16'h0500, 16'h0000, 16'h0200, 0);
    copy(1, 16'h0000, 16'h0000, 16'h0200, 0);
    copy(0, 16'h0203, 16'h0010, 16'h0210, 0);
    copy(1, 16'h0101, 16'h0000, 16'h0200, 0);
    copy(0, 16'hA1FF, 16'h0300, 16'h0000, 0);
    copy(0, 16'h0002, 16'h0100, 16'h0180, 1);
    stop_test;
  end

  // A hang is cut short well after the longest expected run.
  initial begin
    #1000000;
    miscompares++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
